// ==== src/adc_serial_pkg.sv ====
package adc_serial_pkg;

  // Result layout
  localparam int         RES_BITS      = 12;
  localparam int         CNT_W         = 4;
  localparam logic [3:0] CYC_FIRST     = 4'h1;  // Cycle in which the line is first driven low
  localparam logic [3:0] CYC_START13   = 4'hc;  // Edge that opens the 13th cycle
  localparam logic [3:0] CYC_13        = 4'hd;  // Count while the 13th cycle runs
  localparam logic [3:0] CONVERSION_TRIGGER_IDX_BASE = 4'hc;  // Bit index = base - count
  localparam logic [3:0] LSB_FIRST_IDX = 4'h1;
  localparam logic [3:0] LSB_LAST_IDX  = 4'hb;
  localparam logic [11:0] DAC_MSB_TRIAL = 12'h800;

  // Timing, in the units printed
  localparam int SYS_CLK_PS     = 10000;
  localparam int ACQ_MIN_NS     = 350;
  localparam int TRI_MAX_NS     = 100;
  localparam int DATA_VALID_NS  = 50;
  localparam int DRP_MAX_US     = 5;
  // Least time rounds up, longest time rounds down
  localparam int ACQ_CYC        = (ACQ_MIN_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
  localparam int TRI_CYC        = (TRI_MAX_NS * 1000) / SYS_CLK_PS;

  typedef enum logic [2:0] {
    L_SAMPLE,
    L_CONVERT,
    L_LSB,
    L_PDOWN
  } link_state_e;

  typedef enum logic [1:0] {
    MODE_SAMPLE,
    MODE_HOLD,
    MODE_PDOWN
  } mode_e;

  // Toggle events from the link domain to the system domain
  typedef struct packed {
    logic drive;
    logic done;
    logic pdown;
  } link_evt_s;

endpackage : adc_serial_pkg

// ==== src/sync_2ff.sv ====
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : sync_2ff

`default_nettype wire

// ==== src/sar_engine.sv ====
`timescale 1ns/1ps
`default_nettype none

module sar_engine #(
  parameter int RES = adc_serial_pkg::RES_BITS
) (
  // Link clock, falling serial edge
  input  wire logic           clk_in,
  input  wire logic           reset_in,
  // Control
  input  wire logic           clear_in,
  input  wire logic           step_in,
  input  wire logic [3:0]     bit_idx_in,
  input  wire logic           comp_in,
  // Result and trial code
  output logic      [RES-1:0] result_out,
  output logic      [RES-1:0] dac_code_out
);

  logic [RES-1:0] kept;

  always_comb
  begin
    kept             = result_out;
    kept[bit_idx_in] = comp_in;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      result_out   <= '0;
      dac_code_out <= adc_serial_pkg::DAC_MSB_TRIAL;
    end
    else if (clear_in)
    begin
      result_out   <= '0;
      dac_code_out <= adc_serial_pkg::DAC_MSB_TRIAL;
    end
    else if (step_in)
    begin
      // Comparator high keeps the trial bit; next trial sets the bit below
      result_out   <= kept;
      dac_code_out <= (bit_idx_in == 4'h0) ? kept : (kept | (RES'(1) << (bit_idx_in - 4'h1)));
    end
  end

endmodule : sar_engine

`default_nettype wire

// ==== src/sar_adc_serial_conversion_port.sv ====
// Functional notes
// [RULE1] Trigger falling edge moves sample to hold, without any serial clock edge.
// [RULE2] Serial clock may stop while sampling and park high or low afterwards.
// [RULE3] Controller holds trigger high at least 350 ns for acquisition.
// [RULE4] Controller starts serial clock within 5 us of trigger falling.
// [RULE5] Trigger timing violations still convert; first cycle may shift by one.
// [RULE6] Conversion start drives data low; that cycle counts as cycle one.
// [RULE7] Data updates on each falling serial edge, valid within 50 ns.
// [RULE8] Any trigger change floats the data line within 100 ns.
// [RULE9] Trigger low all conversion and at 13th cycle start enters power-down.
// [RULE10] Power-down lasts until trigger rises, then sampling resumes.
// [RULE11] First conversion after power-down is already valid.
// [RULE12] Continuous clock gives sixteen serial periods per conversion.
// [RULE13] Controller may clock fast and convert on demand, idling powered down.
// [RULE14] Trigger may be synchronous to free clock, or asynchronous with gated clock.
// [RULE15] Trigger high before 12th clock end, low in 13th, selects LSB-first.
// [RULE16] LSB-first repeats the remaining 11 bits upward from bit one.
// [RULE17] LSB-first enters power-down, resumes when trigger next rises.
// [RULE18] Result shifts out MSB first, from the conversion in progress.
// [RULE19] Controller keeps serial period 125 ns, each phase 50 ns minimum; the host model clocks at a 32 ns period, 16 ns phases.
// [RULE20] Trigger high at 13th start and not lowered returns to sampling, line floating.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_serial_conversion_port (
  // System clock and reset
  input  wire logic                                  sys_clk_in,
  input  wire logic                                  reset_in,
  // Serial link
  input  wire logic                                  serial_clk_in,
  input  wire logic                                  conversion_trigger_in,
  output logic                                       data_out,
  output logic                                       data_oe_out,
  // Analog core
  input  wire logic                                  comp_in,
  output logic [adc_serial_pkg::RES_BITS-1:0]        dac_code_out,
  output logic                                       hold_out,
  output logic                                       power_down_out,
  output logic                                       acquired_out
);

  localparam int TRI_CYC = adc_serial_pkg::TRI_CYC;
  localparam int ACQ_W   = $clog2(adc_serial_pkg::ACQ_CYC + 1);
  localparam logic [ACQ_W-1:0] ACQ_DONE = ACQ_W'(adc_serial_pkg::ACQ_CYC);

  function automatic logic [3:0] conversion_trigger_bit_idx(input logic [3:0] count);
    conversion_trigger_bit_idx = adc_serial_pkg::CONVERSION_TRIGGER_IDX_BASE - count;
  endfunction : conversion_trigger_bit_idx

  // System domain
  logic                        trig_s;
  logic                        trig_q_reg;
  logic                        trig_fell;
  logic                        trig_rose;
  logic                        start_tog_reg;
  logic                        kill_reg;
  logic [ACQ_W-1:0]            acq_cnt_reg;
  adc_serial_pkg::mode_e       mode_reg;
  adc_serial_pkg::link_evt_s   evt_s;
  adc_serial_pkg::link_evt_s   evt_q_reg;
  adc_serial_pkg::link_evt_s   evt_hit;

  // Link domain
  logic                        link_clk_n;
  logic                        trig_l;
  logic                        start_l;
  logic                        start_q_reg;
  logic                        start_evt;
  adc_serial_pkg::link_state_e l_state_reg;
  logic [3:0]                  cnt_reg;
  logic                        went_high_reg;
  logic                        pd_pend_reg;
  logic                        lsb_pend_reg;
  logic                        link_oe_reg;
  logic                        data_reg;
  adc_serial_pkg::link_evt_s   evt_tog_reg;
  logic [adc_serial_pkg::RES_BITS-1:0] result;
  logic                        conversion_trigger_step;
  logic                        end_pdown;
  logic                        end_lsb;
  logic                        end_sample;
  logic                        lsb_step;
  logic                        lsb_end;

  // Falling serial edges drive the whole link side
  assign link_clk_n = ~serial_clk_in;

  sync_2ff #(.WIDTH(1)) u_trig_sys (
    .clk_in   (sys_clk_in),
    .reset_in (reset_in),
    .async_in (conversion_trigger_in),
    .sync_out (trig_s)
  );

  sync_2ff #(.WIDTH($bits(adc_serial_pkg::link_evt_s))) u_evt_sys (
    .clk_in   (sys_clk_in),
    .reset_in (reset_in),
    .async_in (evt_tog_reg),
    .sync_out (evt_s)
  );

  assign trig_fell = trig_q_reg & ~trig_s;
  assign trig_rose = ~trig_q_reg & trig_s;
  assign evt_hit   = evt_s ^ evt_q_reg;

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      trig_q_reg <= 1'b0;
      evt_q_reg  <= '0;
    end
    else
    begin
      trig_q_reg <= trig_s;
      evt_q_reg  <= evt_s;
    end
  end

  // A start is handed over as a toggle, so a stopped serial clock loses nothing.
  // A fall while a conversion holds the input starts nothing; one in the 13th cycle selects LSB-first.
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      start_tog_reg <= 1'b0;
    else if (trig_fell && (mode_reg != adc_serial_pkg::MODE_HOLD))
      start_tog_reg <= ~start_tog_reg;  // [RULE2] [RULE15]
  end

  // Analog mode; hold needs no serial edge
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      mode_reg <= adc_serial_pkg::MODE_SAMPLE;
    else if (trig_fell)
      mode_reg <= adc_serial_pkg::MODE_HOLD;  // [RULE1] [RULE11]
    else
    begin
      case (mode_reg)
        adc_serial_pkg::MODE_HOLD:
        begin
          if (evt_hit.pdown)
            mode_reg <= adc_serial_pkg::MODE_PDOWN;  // [RULE9] [RULE17]
          else if (evt_hit.done)
            mode_reg <= adc_serial_pkg::MODE_SAMPLE;  // [RULE20]
        end
        adc_serial_pkg::MODE_PDOWN:
        begin
          if (trig_rose)
            mode_reg <= adc_serial_pkg::MODE_SAMPLE;  // [RULE10]
        end
        default:
          mode_reg <= adc_serial_pkg::MODE_SAMPLE;
      endcase
    end
  end

  assign hold_out       = (mode_reg == adc_serial_pkg::MODE_HOLD);
  assign power_down_out = (mode_reg == adc_serial_pkg::MODE_PDOWN);

  // Any trigger change floats the line; a new drive phase releases it, set wins
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      kill_reg <= 1'b1;
    else if (trig_fell | trig_rose)
      kill_reg <= 1'b1;  // [RULE8]
    else if (evt_hit.drive)
      kill_reg <= 1'b0;
  end

  // Tells the analog side when the input has settled
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      acq_cnt_reg <= '0;
    else if (!trig_s)
      acq_cnt_reg <= '0;
    else if (acq_cnt_reg != ACQ_DONE)
      acq_cnt_reg <= acq_cnt_reg + ACQ_W'(1);
  end

  assign acquired_out = (acq_cnt_reg == ACQ_DONE);

  // Enables come from two domains; the pin only ORs in a float request
  assign data_oe_out = link_oe_reg & ~kill_reg;
  assign data_out    = data_reg;

  sync_2ff #(.WIDTH(2)) u_link_sync (
    .clk_in   (link_clk_n),
    .reset_in (reset_in),
    .async_in ({conversion_trigger_in, start_tog_reg}),
    .sync_out ({trig_l, start_l})
  );

  // Asynchronous trigger can land either side of an edge: start may slip a cycle
  always_ff @(posedge link_clk_n or posedge reset_in)
  begin
    if (reset_in)
      start_q_reg <= 1'b0;
    else
      start_q_reg <= start_l;  // [RULE5]
  end

  assign start_evt  = start_l ^ start_q_reg;
  assign conversion_trigger_step  = !start_evt && (l_state_reg == adc_serial_pkg::L_CONVERT) &&
                      (cnt_reg < adc_serial_pkg::CYC_13);
  assign end_pdown  = !start_evt && (l_state_reg == adc_serial_pkg::L_CONVERT) &&
                      (cnt_reg == adc_serial_pkg::CYC_13) && pd_pend_reg;
  assign end_lsb    = !start_evt && (l_state_reg == adc_serial_pkg::L_CONVERT) &&
                      (cnt_reg == adc_serial_pkg::CYC_13) && !pd_pend_reg &&
                      lsb_pend_reg && !trig_l;
  assign end_sample = !start_evt && (l_state_reg == adc_serial_pkg::L_CONVERT) &&
                      (cnt_reg == adc_serial_pkg::CYC_13) && !pd_pend_reg && !end_lsb;
  assign lsb_step   = !start_evt && (l_state_reg == adc_serial_pkg::L_LSB) &&
                      (cnt_reg < adc_serial_pkg::LSB_LAST_IDX);
  assign lsb_end    = !start_evt && (l_state_reg == adc_serial_pkg::L_LSB) &&
                      (cnt_reg == adc_serial_pkg::LSB_LAST_IDX);

  sar_engine #(.RES(adc_serial_pkg::RES_BITS)) u_engine (
    .clk_in       (link_clk_n),
    .reset_in     (reset_in),
    .clear_in     (start_evt),
    .step_in      (conversion_trigger_step),
    .bit_idx_in   (conversion_trigger_bit_idx(cnt_reg)),
    .comp_in      (comp_in),
    .result_out   (result),
    .dac_code_out (dac_code_out)
  );

  // Link state and cycle count
  always_ff @(posedge link_clk_n or posedge reset_in)
  begin
    if (reset_in)
    begin
      l_state_reg <= adc_serial_pkg::L_SAMPLE;
      cnt_reg     <= '0;
    end
    else if (start_evt)
    begin
      l_state_reg <= adc_serial_pkg::L_CONVERT;
      cnt_reg     <= adc_serial_pkg::CYC_FIRST;  // [RULE6]
    end
    else
    begin
      case (l_state_reg)
        adc_serial_pkg::L_CONVERT:
        begin
          if (conversion_trigger_step)
            cnt_reg <= cnt_reg + 4'h1;
          else if (end_pdown)
            l_state_reg <= adc_serial_pkg::L_PDOWN;  // [RULE9]
          else if (end_lsb)
          begin
            l_state_reg <= adc_serial_pkg::L_LSB;  // [RULE15]
            cnt_reg     <= adc_serial_pkg::LSB_FIRST_IDX;
          end
          else
            l_state_reg <= adc_serial_pkg::L_SAMPLE;  // [RULE20]
        end
        adc_serial_pkg::L_LSB:
        begin
          if (lsb_step)
            cnt_reg <= cnt_reg + 4'h1;  // [RULE16]
          else
            l_state_reg <= adc_serial_pkg::L_PDOWN;  // [RULE17]
        end
        adc_serial_pkg::L_PDOWN:
        begin
          if (trig_l)
            l_state_reg <= adc_serial_pkg::L_SAMPLE;  // [RULE10]
        end
        default:
          l_state_reg <= adc_serial_pkg::L_SAMPLE;
      endcase
    end
  end

  // Trigger history inside a conversion
  always_ff @(posedge link_clk_n or posedge reset_in)
  begin
    if (reset_in)
    begin
      went_high_reg <= 1'b0;
      pd_pend_reg   <= 1'b0;
      lsb_pend_reg  <= 1'b0;
    end
    else if (start_evt)
    begin
      went_high_reg <= 1'b0;
      pd_pend_reg   <= 1'b0;
      lsb_pend_reg  <= 1'b0;
    end
    else if (conversion_trigger_step)
    begin
      if (trig_l)
        went_high_reg <= 1'b1;
      if (cnt_reg == adc_serial_pkg::CYC_START13)
      begin
        pd_pend_reg  <= !trig_l && !went_high_reg;  // [RULE9]
        lsb_pend_reg <= trig_l;  // [RULE15]
      end
    end
  end

  // Serial data and its link-side enable
  always_ff @(posedge link_clk_n or posedge reset_in)
  begin
    if (reset_in)
    begin
      link_oe_reg <= 1'b0;
      data_reg    <= 1'b0;
    end
    else if (start_evt)
    begin
      link_oe_reg <= 1'b1;  // [RULE6]
      data_reg    <= 1'b0;
    end
    else if (conversion_trigger_step)
      data_reg <= comp_in;  // [RULE7] [RULE18]
    else if (end_lsb)
      data_reg <= result[adc_serial_pkg::LSB_FIRST_IDX];  // [RULE16]
    else if (lsb_step)
      data_reg <= result[cnt_reg + 4'h1];  // [RULE7]
    else if (end_pdown | end_sample | lsb_end)
      link_oe_reg <= 1'b0;  // [RULE20]
  end

  // Events back to the system domain
  always_ff @(posedge link_clk_n or posedge reset_in)
  begin
    if (reset_in)
      evt_tog_reg <= '0;
    else
    begin
      if (start_evt | end_lsb)
        evt_tog_reg.drive <= ~evt_tog_reg.drive;
      if (end_sample)
        evt_tog_reg.done <= ~evt_tog_reg.done;
      if (end_pdown | lsb_end)
        evt_tog_reg.pdown <= ~evt_tog_reg.pdown;
    end
  end

  AST_HOLD_ON_FALL: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [RULE1]
    trig_fell |=> hold_out && !power_down_out)
    else $error("hold not entered after trigger fall");

  AST_FLOAT_ON_CHANGE: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [RULE8]
    $changed(trig_s) |-> ##[1:TRI_CYC] !data_oe_out)
    else $error("data line not floated after trigger change");

  AST_PD_STAYS: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [RULE10]
    power_down_out && !trig_s && !trig_fell |=> power_down_out)
    else $error("power-down left without trigger rise");

  AST_PD_EXIT: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [RULE10]
    power_down_out && trig_rose |=> !power_down_out && !hold_out)
    else $error("power-down not left on trigger rise");

  AST_FIRST_LOW: assert property (@(posedge link_clk_n) disable iff (reset_in) // [RULE6]
    start_evt |=> link_oe_reg && !data_reg && (cnt_reg == adc_serial_pkg::CYC_FIRST))
    else $error("conversion start did not drive low");

  AST_MSB_FIRST: assert property (@(posedge link_clk_n) disable iff (reset_in) // [RULE18]
    (l_state_reg == adc_serial_pkg::L_CONVERT) && (cnt_reg > adc_serial_pkg::CYC_FIRST)
    |-> data_reg == result[conversion_trigger_bit_idx(cnt_reg - 4'h1)])
    else $error("serial bit does not match current result bit");

  AST_PD_AT_13: assert property (@(posedge link_clk_n) disable iff (reset_in) // [RULE9]
    conversion_trigger_step && (cnt_reg == adc_serial_pkg::CYC_START13) && !trig_l && !went_high_reg
    ##1 !start_evt |=> (l_state_reg == adc_serial_pkg::L_PDOWN) && !link_oe_reg)
    else $error("power-down not entered after 13th cycle");

  AST_RET_SAMPLE: assert property (@(posedge link_clk_n) disable iff (reset_in) // [RULE20]
    end_sample |=> (l_state_reg == adc_serial_pkg::L_SAMPLE) && !link_oe_reg)
    else $error("line not floated on return to sampling");

  AST_LSB_ORDER: assert property (@(posedge link_clk_n) disable iff (reset_in) // [RULE16]
    (l_state_reg == adc_serial_pkg::L_LSB) |-> data_reg == result[cnt_reg])
    else $error("LSB-first bit out of order");

  AST_LSB_LEN: assert property (@(posedge link_clk_n) disable iff (reset_in) // [RULE17]
    end_lsb ##1 (!start_evt)[*8] ##1 !start_evt ##1 !start_evt ##1 !start_evt
    |=> (l_state_reg == adc_serial_pkg::L_PDOWN) && !link_oe_reg)
    else $error("LSB-first readout length wrong");

endmodule : sar_adc_serial_conversion_port

`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // Link to the converter
  output logic      serial_clk_out,
  output logic      trigger_out,
  input  wire logic data_in,
  input  wire logic data_oe_in
);
  logic line;
  logic oe_a [64];
  logic d_a  [64];
  int   s;

  // Pull-up on the line, so a floating line reads high, never as a stale bit
  assign line = (data_oe_in === 1'b1) ? data_in : 1'b1;

  initial
  begin
    serial_clk_out = 1'b0;
    trigger_out    = 1'b1;
  end

  task automatic acquire();
    trigger_out = 1'b1;
    #400;
  endtask : acquire

  // Clock stays still until well after the fall, as a gated controller would
  task automatic hold_now();
    trigger_out = 1'b0;
    #200;
  endtask : hold_now

  // Trigger marks count from the first driven cycle, so a one-cycle slip is absorbed.
  // Marks are in the device's view, which trails the pin by two falling edges.
  task automatic clocks(input int up, input int down, input int n, input logic park);
    s = -1;
    for (int k = 0; k < n; k++)
    begin
      serial_clk_out = 1'b1;
      if (s >= 0 && k - s == up)
        trigger_out = 1'b1;
      if (s >= 0 && k - s == down)
        trigger_out = 1'b0;
      #14;
      oe_a[k] = data_oe_in;
      d_a[k]  = line;
      if (s < 0 && data_oe_in === 1'b1)
        s = k;
      #2;
      serial_clk_out = 1'b0;
      // Limitation: 32 ns period, faster than a real controller keeps; logic has no floor
      #16;
    end
    serial_clk_out = park;
  endtask : clocks

endmodule : host_model

`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t got %h want %h", $time, g, e); end end

module tb_top;
  logic        sys_clk_in;
  logic        reset_in;
  logic        serial_clk;
  logic        trigger;
  logic        data;
  logic        data_oe;
  logic        comp;
  logic        hold;
  logic        pdown;
  logic        acquired;
  logic [11:0] dac_code;
  logic [11:0] vin;
  int          n_errors;
  int          comparisons;

  // Ideal comparator: the search settles on the input code
  assign comp = (vin >= dac_code);

  sar_adc_serial_conversion_port sar_adc_serial_conversion_port_i (
    .sys_clk_in            (sys_clk_in),
    .reset_in              (reset_in),
    .serial_clk_in         (serial_clk),
    .conversion_trigger_in (trigger),
    .data_out              (data),
    .data_oe_out           (data_oe),
    .comp_in               (comp),
    .dac_code_out          (dac_code),
    .hold_out              (hold),
    .power_down_out        (pdown),
    .acquired_out          (acquired)
  );

  host_model host_model_i (
    .serial_clk_out (serial_clk),
    .trigger_out    (trigger),
    .data_in        (data),
    .data_oe_in     (data_oe)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic close_out();
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // One conversion; MSB bits are checked up to the cycle where the trigger rises
  task automatic run(input logic [11:0] v, input int up, input int down, input int n,
                     input logic park);
    vin = v;
    host_model_i.acquire();
    `CHK(acquired, 1'b1)
    `CHK(pdown, 1'b0)
    host_model_i.hold_now();
    `CHK(hold, 1'b1)
    host_model_i.clocks(up, down, n, park);
    if (host_model_i.s < 1 || host_model_i.s > 8)
    begin
      n_errors++;
      $display("BAD %0t no conversion start seen", $time);
      close_out();
    end
    `CHK(host_model_i.d_a[host_model_i.s], 1'b0)
    for (int j = 1; j <= 12 && (up < 0 || j < up); j++)
      `CHK(host_model_i.d_a[host_model_i.s + j], v[12 - j])
    #100;
  endtask : run

  task automatic pd_frame(input logic [11:0] v, input logic park);
    run(v, -1, -1, 24, park);
    `CHK(host_model_i.oe_a[host_model_i.s + 13], 1'b0)
    `CHK(pdown, 1'b1)
    `CHK(hold, 1'b0)
  endtask : pd_frame

  task automatic sample_end(input logic [11:0] v);
    run(v, 8, -1, 24, 1'b0);
    for (int k = 10; k <= 20; k++)
      `CHK(host_model_i.oe_a[host_model_i.s + k], 1'b0)
    `CHK(pdown, 1'b0)
    `CHK(hold, 1'b0)
  endtask : sample_end

  task automatic lsb_frame(input logic [11:0] v);
    run(v, 8, 10, 40, 1'b0);
    `CHK(host_model_i.oe_a[host_model_i.s + 11], 1'b0)
    // Bit one may land before the enable comes back, so the check starts at bit two
    for (int b = 2; b <= 11; b++)
    begin
      `CHK(host_model_i.oe_a[host_model_i.s + 12 + b], 1'b1)
      `CHK(host_model_i.d_a[host_model_i.s + 12 + b], v[b])
    end
    `CHK(host_model_i.oe_a[host_model_i.s + 24], 1'b0)
    `CHK(pdown, 1'b1)
    `CHK(hold, 1'b0)
  endtask : lsb_frame

  initial
  begin
    n_errors    = 0;
    comparisons = 0;
    vin         = 12'h000;
    reset_in    = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    reset_in = 1'b0;
    pd_frame(12'ha5c, 1'b0);
    pd_frame(12'h7ff, 1'b1);
    sample_end(12'hfff);
    lsb_frame(12'h3a6);
    pd_frame(12'h5a3, 1'b0);
    close_out();
  end

endmodule : tb_top

`default_nettype wire
